// ==== design/isam_defines.vh ====
// isam_defines.vh: offsets, field positions, reset values and state codes
// for the two-wire status and address mask block.
// assumes: included by bare name from the design files under design/.
`ifndef ISAM_DEFINES_VH
`define ISAM_DEFINES_VH

// ****************************************
// register word indices (byte address = 4 * index)
// ****************************************
`define ISAM_IDX_STATUS 3'h0
`define ISAM_IDX_MASK 3'h1
`define ISAM_IDX_OWN_ADDR 3'h2
`define ISAM_IDX_RX_HOLD 3'h3
`define ISAM_IDX_TX_HOLD 3'h4
`define ISAM_IDX_INT_STATUS 3'h5
`define ISAM_IDX_INT_MASK 3'h6

// ****************************************
// status register fields
// ****************************************
`define ISAM_ST_TX_FULL 0
`define ISAM_ST_RX_FULL 1
`define ISAM_ST_RW 2
`define ISAM_ST_START 3
`define ISAM_ST_STOP 4
`define ISAM_ST_DA 5
`define ISAM_ST_ACK 15

// ****************************************
// interrupt event bits
// ****************************************
`define ISAM_EV_MATCH 0
`define ISAM_EV_RX 1
`define ISAM_EV_TX_DONE 2
`define ISAM_EV_STOP 3
`define ISAM_EV_W 4

// ****************************************
// widths and reset values
// ****************************************
`define ISAM_MASK_W 10
`define ISAM_MASK_RST 10'h000
`define ISAM_OWN_ADDR_RST 7'h00
`define ISAM_BIT_LAST 3'h7

// ****************************************
// slave engine states, one-hot
// ****************************************
`define ISAM_S_IDLE 7'h01
`define ISAM_S_ADDR 7'h02
`define ISAM_S_AACK 7'h04
`define ISAM_S_RX 7'h08
`define ISAM_S_RACK 7'h10
`define ISAM_S_TX 7'h20
`define ISAM_S_TACK 7'h40

`endif

// ==== design/isam_sync.v ====
// isam_sync.v: two flip-flop synchroniser for a group of pin levels.
// assumes: inputs are asynchronous to clk_in; outputs feed the clk_in domain.
`timescale 1ns/1ps
module isam_sync #(
    parameter WIDTH = 2
) (
    // clock and reset
    input wire clk_in,
    input wire rst_in,
    // levels
    input wire [WIDTH-1:0] async_in,
    output wire [WIDTH-1:0] sync_out
);
    reg [WIDTH-1:0] meta_reg;
    reg [WIDTH-1:0] sync_reg;

    // idle bus is high, so reset to ones to avoid a false start
    always @(posedge clk_in) begin
        if (rst_in) begin
            meta_reg <= {WIDTH{1'b1}};
            sync_reg <= {WIDTH{1'b1}};
        end else begin
            meta_reg <= async_in;
            sync_reg <= meta_reg;
        end
    end

    assign sync_out = sync_reg;
endmodule // isam_sync

// ==== design/isam_addr_match.v ====
// isam_addr_match.v: masked compare of an incoming address against our own.
// assumes: purely combinational, used by the slave engine in isam_top.
`timescale 1ns/1ps
`include "isam_defines.vh"
module isam_addr_match (
    // operands
    input wire [`ISAM_MASK_W-1:0] incoming_in,
    input wire [`ISAM_MASK_W-1:0] own_in,
    input wire [`ISAM_MASK_W-1:0] mask_in,
    // result
    output wire match_out
);
    wire [`ISAM_MASK_W-1:0] bit_ok;

    genvar i;
    generate
        for (i = 0; i < `ISAM_MASK_W; i = i + 1) begin : g_bit
            // masked bit always passes, else it must be equal
            assign bit_ok[i] = mask_in[i] | (incoming_in[i] == own_in[i]);
        end
    endgenerate

    assign match_out = &bit_ok;
endmodule // isam_addr_match

// ==== design/isam_top.v ====
// isam_top.v: status flags, address mask and a compact two-wire slave engine
// with an Avalon-MM register slave and one level interrupt.
// assumes: scl/sda pins are open drain with pull-ups outside; clk_in is
// far faster than scl so every scl edge is seen after synchronising.
`timescale 1ns/1ps
`include "isam_defines.vh"
module isam_top (
    // clock and reset
    input wire clk_in,
    input wire rst_in,
    // avalon-mm slave
    input wire [2:0] avs_address_in,
    input wire avs_read_in,
    input wire avs_write_in,
    input wire [31:0] avs_writedata_in,
    input wire [3:0] avs_byteenable_in,
    output wire [31:0] avs_readdata_out,
    output wire avs_waitrequest_out,
    // two-wire bus pins
    input wire scl_in,
    input wire sda_in,
    output wire sda_out,
    output wire sda_oe_out,
    // interrupt
    output wire irq_out
);

    // ****************************************
    // pin synchronisers and bus condition detect
    // ****************************************
    wire [1:0] pins_sync;
    wire scl_s;
    wire sda_s;
    reg scl_q_reg;
    reg sda_q_reg;

    isam_sync #(.WIDTH(2)) u_sync (
        .clk_in(clk_in),
        .rst_in(rst_in),
        .async_in({scl_in, sda_in}),
        .sync_out(pins_sync)
    );

    assign scl_s = pins_sync[1];
    assign sda_s = pins_sync[0];

    always @(posedge clk_in) begin
        if (rst_in) begin
            scl_q_reg <= 1'b1;
            sda_q_reg <= 1'b1;
        end else begin
            scl_q_reg <= scl_s;
            sda_q_reg <= sda_s;
        end
    end

    wire scl_rise = scl_s & ~scl_q_reg;
    wire scl_fall = ~scl_s & scl_q_reg;
    wire start_det = scl_s & scl_q_reg & sda_q_reg & ~sda_s;
    wire stop_det = scl_s & scl_q_reg & ~sda_q_reg & sda_s;

    // ****************************************
    // software registers
    // ****************************************
    reg [`ISAM_MASK_W-1:0] mask_reg;
    reg [6:0] own_addr_reg;
    reg [7:0] rx_hold_reg;
    reg [7:0] tx_hold_reg;
    reg [`ISAM_EV_W-1:0] int_status_reg;
    reg [`ISAM_EV_W-1:0] int_mask_reg;
    reg da_reg;
    reg stop_reg;
    reg start_reg;
    reg rw_reg;
    reg rx_buffer_full_flag_reg;
    reg tx_buffer_full_flag_reg;
    reg acknowledge_status_flag_reg;

    // ****************************************
    // avalon-mm access: one wait cycle, then answer
    // ****************************************
    reg resp_reg;
    reg [31:0] readdata_reg;
    wire req = avs_read_in | avs_write_in;
    wire wr_take = avs_write_in & resp_reg;
    wire rd_take = avs_read_in & resp_reg;

    assign avs_waitrequest_out = req & ~resp_reg;
    assign avs_readdata_out = readdata_reg;

    wire [15:0] status_word = {acknowledge_status_flag_reg, 9'h000, da_reg, stop_reg,
                               start_reg, rw_reg, rx_buffer_full_flag_reg,
                               tx_buffer_full_flag_reg};

    always @(posedge clk_in) begin
        if (rst_in) begin
            resp_reg <= 1'b0;
        end else begin
            resp_reg <= req & ~resp_reg;
        end
    end

    // read data is latched in the wait cycle, so it stands at the taking edge
    always @(posedge clk_in) begin
        if (rst_in) begin
            readdata_reg <= 32'h0000_0000;
        end else if (avs_read_in & ~resp_reg) begin
            case (avs_address_in)
                `ISAM_IDX_STATUS: readdata_reg <= {16'h0000, status_word};
                `ISAM_IDX_MASK: readdata_reg <= {22'h000000, mask_reg};
                `ISAM_IDX_OWN_ADDR: readdata_reg <= {25'h0000000, own_addr_reg};
                `ISAM_IDX_RX_HOLD: readdata_reg <= {24'h000000, rx_hold_reg};
                `ISAM_IDX_TX_HOLD: readdata_reg <= {24'h000000, tx_hold_reg};
                `ISAM_IDX_INT_STATUS: readdata_reg <= {28'h0000000, int_status_reg};
                `ISAM_IDX_INT_MASK: readdata_reg <= {28'h0000000, int_mask_reg};
                default: readdata_reg <= 32'h0000_0000;
            endcase
        end
    end

    wire wr_mask = wr_take && (avs_address_in == `ISAM_IDX_MASK);
    wire wr_own = wr_take && (avs_address_in == `ISAM_IDX_OWN_ADDR) && avs_byteenable_in[0];
    wire wr_tx = wr_take && (avs_address_in == `ISAM_IDX_TX_HOLD) && avs_byteenable_in[0];
    wire wr_ist = wr_take && (avs_address_in == `ISAM_IDX_INT_STATUS) && avs_byteenable_in[0];
    wire wr_imk = wr_take && (avs_address_in == `ISAM_IDX_INT_MASK) && avs_byteenable_in[0];
    wire rd_rx = rd_take && (avs_address_in == `ISAM_IDX_RX_HOLD);

    always @(posedge clk_in) begin
        if (rst_in) begin
            mask_reg <= `ISAM_MASK_RST;
            own_addr_reg <= `ISAM_OWN_ADDR_RST;
            tx_hold_reg <= 8'h00;
            int_mask_reg <= {`ISAM_EV_W{1'b0}};
        end else begin
            // upper bits of the word are simply not stored
            if (wr_mask && avs_byteenable_in[0]) begin
                mask_reg[7:0] <= avs_writedata_in[7:0];
            end
            if (wr_mask && avs_byteenable_in[1]) begin
                mask_reg[9:8] <= avs_writedata_in[9:8];
            end
            if (wr_own) begin
                own_addr_reg <= avs_writedata_in[6:0];
            end
            if (wr_tx) begin
                tx_hold_reg <= avs_writedata_in[7:0];
            end
            if (wr_imk) begin
                int_mask_reg <= avs_writedata_in[`ISAM_EV_W-1:0];
            end
        end
    end

    // ****************************************
    // address compare
    // ****************************************
    reg [7:0] shift_reg;
    wire [7:0] byte_in = {shift_reg[6:0], sda_s};
    wire addr_match;

    isam_addr_match u_match (
        .incoming_in({3'h0, byte_in[7:1]}),
        .own_in({3'h0, own_addr_reg}),
        .mask_in(mask_reg),
        .match_out(addr_match)
    );

    // ****************************************
    // slave engine
    // ****************************************
    localparam S_IDLE = `ISAM_S_IDLE;
    localparam S_ADDR = `ISAM_S_ADDR;
    localparam S_AACK = `ISAM_S_AACK;
    localparam S_RX = `ISAM_S_RX;
    localparam S_RACK = `ISAM_S_RACK;
    localparam S_TX = `ISAM_S_TX;
    localparam S_TACK = `ISAM_S_TACK;

    reg [6:0] state_reg;
    reg [2:0] bit_cnt_reg;
    reg drive_low_reg;
    reg ack_phase_reg;
    reg ack_seen_reg;
    reg ev_match;
    reg ev_rx;
    reg ev_tx_done;

    // no clock stretching: a read is served from whatever the holder has
    always @(posedge clk_in) begin
        if (rst_in) begin
            state_reg <= S_IDLE;
            bit_cnt_reg <= 3'h0;
            shift_reg <= 8'h00;
            drive_low_reg <= 1'b0;
            ack_phase_reg <= 1'b0;
            ack_seen_reg <= 1'b0;
            rw_reg <= 1'b0;
            acknowledge_status_flag_reg <= 1'b0;
            rx_hold_reg <= 8'h00;
            ev_match <= 1'b0;
            ev_rx <= 1'b0;
            ev_tx_done <= 1'b0;
        end else begin
            ev_match <= 1'b0;
            ev_rx <= 1'b0;
            ev_tx_done <= 1'b0;
            if (start_det) begin
                state_reg <= S_ADDR;
                bit_cnt_reg <= 3'h0;
                drive_low_reg <= 1'b0;
            end else if (stop_det) begin
                state_reg <= S_IDLE;
                drive_low_reg <= 1'b0;
            end else begin
                case (state_reg)
                    S_IDLE: begin
                        drive_low_reg <= 1'b0;
                    end
                    S_ADDR: begin
                        if (scl_rise) begin
                            shift_reg <= byte_in;
                            bit_cnt_reg <= bit_cnt_reg + 3'h1;
                            if (bit_cnt_reg == `ISAM_BIT_LAST) begin
                                if (addr_match) begin
                                    rw_reg <= byte_in[0];
                                    ev_match <= 1'b1;
                                    ack_phase_reg <= 1'b0;
                                    state_reg <= S_AACK;
                                end else begin
                                    state_reg <= S_IDLE;
                                end
                            end
                        end
                    end
                    S_AACK, S_RACK: begin
                        if (scl_fall) begin
                            if (!ack_phase_reg) begin
                                ack_phase_reg <= 1'b1;
                                drive_low_reg <= 1'b1;
                            end else if ((state_reg == S_AACK) && rw_reg) begin
                                shift_reg <= tx_hold_reg;
                                drive_low_reg <= ~tx_hold_reg[7];
                                bit_cnt_reg <= 3'h0;
                                state_reg <= S_TX;
                            end else begin
                                drive_low_reg <= 1'b0;
                                bit_cnt_reg <= 3'h0;
                                state_reg <= S_RX;
                            end
                        end
                    end
                    S_RX: begin
                        if (scl_rise) begin
                            shift_reg <= byte_in;
                            bit_cnt_reg <= bit_cnt_reg + 3'h1;
                            if (bit_cnt_reg == `ISAM_BIT_LAST) begin
                                rx_hold_reg <= byte_in;
                                ev_rx <= 1'b1;
                                ack_phase_reg <= 1'b0;
                                state_reg <= S_RACK;
                            end
                        end
                    end
                    S_TX: begin
                        if (scl_fall) begin
                            if (bit_cnt_reg == `ISAM_BIT_LAST) begin
                                drive_low_reg <= 1'b0;
                                ack_seen_reg <= 1'b0;
                                state_reg <= S_TACK;
                            end else begin
                                shift_reg <= {shift_reg[6:0], 1'b0};
                                drive_low_reg <= ~shift_reg[6];
                                bit_cnt_reg <= bit_cnt_reg + 3'h1;
                            end
                        end
                    end
                    S_TACK: begin
                        if (scl_rise) begin
                            acknowledge_status_flag_reg <= sda_s;
                            ev_tx_done <= 1'b1;
                            ack_seen_reg <= ~sda_s;
                            if (sda_s) begin
                                state_reg <= S_IDLE;
                            end
                        end else if (scl_fall && ack_seen_reg) begin
                            shift_reg <= tx_hold_reg;
                            drive_low_reg <= ~tx_hold_reg[7];
                            bit_cnt_reg <= 3'h0;
                            state_reg <= S_TX;
                        end
                    end
                    default: begin
                        state_reg <= S_IDLE;
                        drive_low_reg <= 1'b0;
                    end
                endcase
            end
        end
    end

    // open drain: only ever pull low
    assign sda_out = 1'b0;
    assign sda_oe_out = drive_low_reg;

    // ****************************************
    // status flags
    // ****************************************
    always @(posedge clk_in) begin
        if (rst_in) begin
            da_reg <= 1'b0;
            stop_reg <= 1'b0;
            start_reg <= 1'b0;
            rx_buffer_full_flag_reg <= 1'b0;
            tx_buffer_full_flag_reg <= 1'b0;
        end else begin
            if (ev_match) begin
                da_reg <= 1'b0;
            end else if (wr_tx || ev_rx) begin
                da_reg <= 1'b1;
            end
            if (start_det) begin
                start_reg <= 1'b1;
                stop_reg <= 1'b0;
            end else if (stop_det) begin
                start_reg <= 1'b0;
                stop_reg <= 1'b1;
            end
            // set wins over a clear in the same cycle
            if (ev_rx) begin
                rx_buffer_full_flag_reg <= 1'b1;
            end else if (rd_rx) begin
                rx_buffer_full_flag_reg <= 1'b0;
            end
            if (wr_tx) begin
                tx_buffer_full_flag_reg <= 1'b1;
            end else if (ev_tx_done) begin
                tx_buffer_full_flag_reg <= 1'b0;
            end
        end
    end

    // ****************************************
    // interrupt status, write one to clear
    // ****************************************
    wire [`ISAM_EV_W-1:0] events = {stop_det, ev_tx_done, ev_rx, ev_match};
    wire [`ISAM_EV_W-1:0] clr_bits = wr_ist ? avs_writedata_in[`ISAM_EV_W-1:0]
                                            : {`ISAM_EV_W{1'b0}};

    always @(posedge clk_in) begin
        if (rst_in) begin
            int_status_reg <= {`ISAM_EV_W{1'b0}};
        end else begin
            int_status_reg <= (int_status_reg & ~clr_bits) | events;
        end
    end

    assign irq_out = |(int_status_reg & int_mask_reg);

endmodule // isam_top

// ==== tb/isam_props.sv ====
// isam_props.sv: port-level checks for isam_top.
// assumes: bound to isam_top; one clock domain with synchronous reset.
`timescale 1ns/1ps
`include "isam_defines.vh"
module isam_props (
    // clock and reset
    input wire clk_in,
    input wire rst_in,
    // register bus
    input wire [2:0] avs_address_in,
    input wire avs_read_in,
    input wire avs_write_in,
    input wire [31:0] avs_writedata_in,
    input wire [3:0] avs_byteenable_in,
    input wire [31:0] avs_readdata_out,
    input wire avs_waitrequest_out,
    // pins and interrupt
    input wire scl_in,
    input wire sda_in,
    input wire sda_out,
    input wire sda_oe_out,
    input wire irq_out
);
    // ****
    // helper state
    // ****
    logic scl_reg, sda_reg, start_reg, stop_reg, rx_rd_reg, tx_wr_reg;
    logic [3:0] quiet_reg;
    wire req = avs_read_in || avs_write_in;
    wire done = req && !avs_waitrequest_out;
    wire st_rd = done && avs_read_in && avs_address_in == `ISAM_IDX_STATUS;
    wire cond = scl_in && scl_reg && sda_in != sda_reg;
    wire moved = scl_in != scl_reg;
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            scl_reg <= 1'b1;
            sda_reg <= 1'b1;
            start_reg <= 1'b0;
            stop_reg <= 1'b0;
            rx_rd_reg <= 1'b0;
            tx_wr_reg <= 1'b0;
            quiet_reg <= 4'hf;
        end else begin
            scl_reg <= scl_in;
            sda_reg <= sda_in;
            // flags lag the pins by the synchronisers, so wait until quiet
            quiet_reg <= cond ? 4'h0 : quiet_reg + {3'h0, quiet_reg != 4'hf};
            if (cond) begin
                start_reg <= !sda_in;
                stop_reg <= sda_in;
            end
            rx_rd_reg <= (done && avs_read_in && avs_address_in == `ISAM_IDX_RX_HOLD)
                || (rx_rd_reg && !moved);
            tx_wr_reg <= (done && avs_write_in && avs_address_in == `ISAM_IDX_TX_HOLD)
                || (tx_wr_reg && !moved);
        end
    end
    // ****
    // assertions
    // ****
    default clocking cb @(posedge clk_in);
    endclocking
    default disable iff (rst_in);
    property p_one_wait;
        req && avs_waitrequest_out |=> !avs_waitrequest_out;
    endproperty
    a_one_wait: assert property (p_one_wait) else $error("wait longer than one cycle");
    property p_idle;
        !req |-> !avs_waitrequest_out;
    endproperty
    a_idle: assert property (p_idle) else $error("waitrequest while idle");
    property p_mask_hi;
        done && avs_read_in && avs_address_in == `ISAM_IDX_MASK |-> avs_readdata_out[31:10] == 22'h0;
    endproperty
    a_mask_hi: assert property (p_mask_hi) else $error("mask upper bits set");
    property p_stat_rsvd;
        st_rd |-> avs_readdata_out[31:16] == 16'h0 && avs_readdata_out[14:6] == 9'h0;
    endproperty
    a_stat_rsvd: assert property (p_stat_rsvd) else $error("status spare bits set");
    property p_start_last;
        st_rd && quiet_reg == 4'hf |-> avs_readdata_out[`ISAM_ST_START] == start_reg;
    endproperty
    a_start_last: assert property (p_start_last) else $error("start flag wrong");
    property p_stop_last;
        st_rd && quiet_reg == 4'hf |-> avs_readdata_out[`ISAM_ST_STOP] == stop_reg;
    endproperty
    a_stop_last: assert property (p_stop_last) else $error("stop flag wrong");
    property p_rx_clear;
        st_rd && rx_rd_reg |-> !avs_readdata_out[`ISAM_ST_RX_FULL];
    endproperty
    a_rx_clear: assert property (p_rx_clear) else $error("rx full after read");
    property p_tx_full;
        st_rd && tx_wr_reg |-> avs_readdata_out[`ISAM_ST_TX_FULL];
    endproperty
    a_tx_full: assert property (p_tx_full) else $error("tx full not set");
    property p_tx_da;
        st_rd && tx_wr_reg |-> avs_readdata_out[`ISAM_ST_DA];
    endproperty
    a_tx_da: assert property (p_tx_da) else $error("data flag not set");
    property p_irq_off;
        done && avs_write_in && avs_address_in == `ISAM_IDX_INT_MASK
            && avs_writedata_in[7:0] == 8'h0 |=> !irq_out;
    endproperty
    a_irq_off: assert property (p_irq_off) else $error("irq with all masked");
endmodule // isam_props
bind isam_top isam_props i_isam_props (.clk_in(clk_in), .rst_in(rst_in),
    .avs_address_in(avs_address_in), .avs_read_in(avs_read_in), .avs_write_in(avs_write_in),
    .avs_writedata_in(avs_writedata_in), .avs_byteenable_in(avs_byteenable_in),
    .avs_readdata_out(avs_readdata_out), .avs_waitrequest_out(avs_waitrequest_out),
    .scl_in(scl_in), .sda_in(sda_in), .sda_out(sda_out), .sda_oe_out(sda_oe_out),
    .irq_out(irq_out));

// ==== tb/isam_i2c_master.sv ====
// isam_i2c_master.sv: behavioural two-wire bus master facing isam_top.
// assumes: tasks start right after a rising clk_in edge; sda has a pull-up.
`timescale 1ns/1ps
module isam_i2c_master (
    // clock
    input wire clk_in,
    // bus pins
    input wire sda_in,
    output logic scl_out,
    output logic sda_low_out
);
    // scl stands high between frames and low between bytes
    initial begin
        scl_out = 1'b1;
        sda_low_out = 1'b0;
    end
    // a quarter of the 320 ns bus period is two system clocks
    task automatic quarter();
        repeat (2) @(posedge clk_in);
    endtask
    task automatic start();
        sda_low_out <= 1'b0;
        quarter();
        scl_out <= 1'b1;
        quarter();
        sda_low_out <= 1'b1;
        quarter();
        scl_out <= 1'b0;
        quarter();
    endtask
    // bus-free time after stop lets the slave flags settle
    task automatic stop();
        sda_low_out <= 1'b1;
        quarter();
        scl_out <= 1'b1;
        quarter();
        sda_low_out <= 1'b0;
        repeat (3) quarter();
    endtask
    // data moves only while scl is low; sampled mid high phase
    task automatic bit_io(input logic b, output logic r);
        sda_low_out <= !b;
        quarter();
        scl_out <= 1'b1;
        quarter();
        r = sda_in;
        quarter();
        scl_out <= 1'b0;
        quarter();
    endtask
    task automatic byte_io(input logic [7:0] d, input logic m_ack, output logic [7:0] q,
                           output logic ack_n);
        for (int i = 7; i >= 0; i--) bit_io(d[i], q[i]);
        bit_io(m_ack, ack_n);
    endtask
endmodule // isam_i2c_master

// ==== tb/isam_top_tb.sv ====
// isam_top_tb.sv: self-checking bench for isam_top.
// assumes: isam_i2c_master drives the pins; sda is an open-drain wire with pull-up.
`timescale 1ns/1ps
`include "isam_defines.vh"
`define CHK(got, exp) begin checked++; if ((got) !== (exp)) begin err_total++; \
    $display("ERROR %0t: got %0h expected %0h", $time, got, exp); end end
module isam_top_tb;
    logic clk_in = 1'b0;
    logic rst_in = 1'b1;
    logic [2:0] avs_address_in = 3'h0;
    logic avs_read_in = 1'b0;
    logic avs_write_in = 1'b0;
    logic [31:0] avs_writedata_in = 32'h0;
    wire [31:0] avs_readdata_out;
    wire avs_waitrequest_out, scl_in, sda_in, sda_out, sda_oe_out, irq_out, m_low;
    int err_total = 0;
    int checked = 0;
    logic [7:0] q;
    logic a;
    always #20 clk_in = !clk_in;
    assign sda_in = !(m_low || (sda_oe_out && !sda_out));
    isam_top i_isam_top (.clk_in(clk_in), .rst_in(rst_in), .avs_address_in(avs_address_in),
        .avs_read_in(avs_read_in), .avs_write_in(avs_write_in),
        .avs_writedata_in(avs_writedata_in), .avs_byteenable_in(4'hf),
        .avs_readdata_out(avs_readdata_out), .avs_waitrequest_out(avs_waitrequest_out),
        .scl_in(scl_in), .sda_in(sda_in), .sda_out(sda_out), .sda_oe_out(sda_oe_out),
        .irq_out(irq_out));
    isam_i2c_master i_isam_i2c_master (.clk_in(clk_in), .sda_in(sda_in), .scl_out(scl_in),
        .sda_low_out(m_low));
    // ****
    // tasks
    // ****
    task automatic end_sim();
        $display("checked %0d err_total %0d", checked, err_total);
        if (err_total == 0 && checked > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    // waitrequest and read data are taken at the rising edge, before it updates them
    task automatic bus(input logic wr, input logic [2:0] ad, input logic [31:0] d,
                       output logic [31:0] r);
        logic w;
        int n;
        n = 0;
        avs_read_in <= !wr;
        avs_write_in <= wr;
        avs_address_in <= ad;
        avs_writedata_in <= d;
        do begin
            @(posedge clk_in);
            w = avs_waitrequest_out;
            r = avs_readdata_out;
            n++;
        end while (w !== 1'b0 && n < 64);
        `CHK(w, 1'b0)
        avs_read_in <= 1'b0;
        avs_write_in <= 1'b0;
        @(posedge clk_in);
    endtask
    task automatic wr(input logic [2:0] ad, input logic [31:0] d);
        logic [31:0] r;
        bus(1'b1, ad, d, r);
    endtask
    task automatic rdc(input logic [2:0] ad, input logic [31:0] exp);
        logic [31:0] r;
        bus(1'b0, ad, 32'h0, r);
        `CHK(r, exp)
    endtask
    task automatic probe(input logic [6:0] ad, input logic exp_nack);
        i_isam_i2c_master.start();
        i_isam_i2c_master.byte_io({ad, 1'b0}, 1'b1, q, a);
        i_isam_i2c_master.stop();
        `CHK(a, exp_nack)
    endtask
    // ****
    // sequence
    // ****
    initial begin
        repeat (20000) @(posedge clk_in);
        err_total++;
        $display("ERROR %0t: timeout", $time);
        end_sim();
    end
    initial begin
        repeat (3) @(posedge clk_in);
        rst_in <= 1'b0;
        @(posedge clk_in);
        rdc(`ISAM_IDX_STATUS, 32'h0);
        rdc(`ISAM_IDX_MASK, 32'h0);
        wr(`ISAM_IDX_MASK, 32'hffff_ffff);
        rdc(`ISAM_IDX_MASK, 32'h3ff);
        rdc(3'h7, 32'h0);
        wr(`ISAM_IDX_OWN_ADDR, 32'h2a);
        for (int i = 0; i < 7; i++) begin
            wr(`ISAM_IDX_MASK, 32'h0);
            probe(7'h2a ^ (7'h1 << i), 1'b1);
            wr(`ISAM_IDX_MASK, 32'h1 << i);
            probe(7'h2a ^ (7'h1 << i), 1'b0);
        end
        // slave transmit, master answers with nack
        wr(`ISAM_IDX_MASK, 32'h0);
        wr(`ISAM_IDX_TX_HOLD, 32'hc3);
        rdc(`ISAM_IDX_STATUS, 32'h31);
        i_isam_i2c_master.start();
        i_isam_i2c_master.byte_io({7'h2a, 1'b1}, 1'b1, q, a);
        `CHK(a, 1'b0)
        rdc(`ISAM_IDX_STATUS, 32'hd);
        i_isam_i2c_master.byte_io(8'hff, 1'b1, q, a);
        `CHK(q, 8'hc3)
        i_isam_i2c_master.stop();
        rdc(`ISAM_IDX_STATUS, 32'h8014);
        // slave receive; acknowledge flag keeps its old value
        wr(`ISAM_IDX_MASK, 32'h1);
        i_isam_i2c_master.start();
        i_isam_i2c_master.byte_io({7'h2b, 1'b0}, 1'b1, q, a);
        `CHK(a, 1'b0)
        rdc(`ISAM_IDX_STATUS, 32'h8008);
        i_isam_i2c_master.byte_io(8'h5a, 1'b1, q, a);
        rdc(`ISAM_IDX_STATUS, 32'h802a);
        rdc(`ISAM_IDX_RX_HOLD, 32'h5a);
        rdc(`ISAM_IDX_STATUS, 32'h8028);
        i_isam_i2c_master.stop();
        // interrupts: raise, mask, clear
        rdc(`ISAM_IDX_INT_STATUS, 32'hf);
        `CHK(irq_out, 1'b0)
        wr(`ISAM_IDX_INT_MASK, 32'h2);
        `CHK(irq_out, 1'b1)
        wr(`ISAM_IDX_INT_STATUS, 32'h2);
        `CHK(irq_out, 1'b0)
        rdc(`ISAM_IDX_INT_STATUS, 32'hd);
        wr(`ISAM_IDX_INT_MASK, 32'hd);
        `CHK(irq_out, 1'b1)
        wr(`ISAM_IDX_INT_MASK, 32'h0);
        `CHK(irq_out, 1'b0)
        wr(`ISAM_IDX_INT_STATUS, 32'hd);
        rdc(`ISAM_IDX_INT_STATUS, 32'h0);
        wr(`ISAM_IDX_STATUS, 32'hffff_ffff);
        rdc(`ISAM_IDX_STATUS, 32'h8030);
        end_sim();
    end
endmodule // isam_top_tb
